// >>> wdm_pkg.sv
// Constants and types shared by the windowed watchdog and clock monitor.
package wdm_pkg;

  // Register map, byte addresses on the AXI4-Lite slave.
  localparam int unsigned AXI_AW = 6;
  localparam logic [3:0] OFF_SERVICE = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_IDLE_CTRL = 4'h8;
  localparam logic [3:0] OFF_IDLE_COUNT = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status register bit positions.
  localparam int unsigned STAT_FIRST_DONE = 0;
  localparam int unsigned STAT_WD_FAULT = 1;
  localparam int unsigned STAT_CM_FAULT = 2;
  localparam int unsigned STAT_PIN_LEVEL = 3;
  localparam int unsigned STAT_PENDING = 4;

  // Service byte layout and values.
  localparam logic [4:0] SVC_KEY = 5'h0c;
  localparam logic [4:0] SVC_KEY_READ = 5'h00;
  localparam logic [1:0] WIN_MAX = 2'h3;
  localparam logic CM_EN_RESET = 1'b1;

  // Window timing in idle-timer clocks.
  localparam int unsigned WIN_W = 17;
  localparam logic [16:0] LOWER_LIMIT = 17'h0_0800;
  localparam logic [16:0] UPPER_BASE = 17'h0_2000;
  localparam logic [4:0] FAULT_HOLD_TICKS = 5'h10;
  localparam logic [4:0] CM_RECOVER_TICKS = 5'h10;

  // Idle timer and its pending-flag tap (4k up to 64k clocks).
  localparam int unsigned IDLE_W = 17;
  localparam int unsigned TAP_BASE = 12;
  localparam logic [2:0] TAP_SEL_MAX = 3'h4;
  localparam logic [2:0] TAP_SEL_RESET = 3'h0;

  // Clock monitor rejection time: a 10 Hz clock period.
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CM_REJECT_NS = 100_000_000;
  localparam int unsigned CM_REJECT_CYCLES = CM_REJECT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] win;
    logic [4:0] key;
    logic cm_en;
  } wdm_svc_t;

  typedef enum logic [2:0] {
    WD_RUN = 3'b001,
    WD_DRIVE = 3'b010,
    WD_RELEASE = 3'b100
  } wdm_state_t;

endpackage : wdm_pkg

// >>> wdm_sync3.sv
// Three-stage input synchroniser whose output follows agreeing late stages.
`timescale 1ns/1ps
`default_nettype none

module wdm_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic dout_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is taken only once two settled stages agree, filtering glitches.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dout_q <= RESET_VAL;
    else if (s2_q == s3_q)
      dout_q <= s3_q;
  end

  assign dout = dout_q;

endmodule : wdm_sync3

`default_nettype wire

// >>> wdm_top.sv
// Windowed watchdog with clock monitor, idle timer and AXI4-Lite registers.
//
// Notes on behaviour
// RULE1: Reset holds both detectors idle; no fault can be driven.
// RULE2: After reset both detectors run, window set to the largest choice.
// RULE3: Window and monitor enable taken only from first service, then frozen.
// RULE4: First service checks only the key; a wrong key raises a fault.
// RULE5: Later services must repeat window, key and monitor bit exactly.
// RULE6: Reading the service register shows zeros in the key field.
// RULE7: Window checking pauses while the processor halts or idles.
// RULE8: Clock monitor keeps running in halt and idle, flagging a stopped clock.
// RULE9: A clock fault pulls the shared fault pin low like a watchdog fault.
// RULE10: Leaving halt restarts the window; software waits the lower limit.
// RULE11: Ordinary reset leaves the idle timer count untouched.
// RULE12: Pending flag sets on each selected tap toggle; software clears it.
// RULE13: Leaving idle services automatically; early software service faults.
// RULE14: The first service may come early without an early-service fault.
// RULE15: Boot return services and re-arms lower-limit checking.
// RULE16: Window codes pick 8k, 16k, 32k, 64k; lower limit is 2048.
// RULE17: Service byte: window bits 7:6, key bits 5:1, monitor bit 0.
// RULE18: A fully matching service restarts the window; mismatch faults.
// RULE19: Hold pin low 16 ticks after it reads low, ignore services meanwhile.
// RULE20: Expiry of the upper limit or a too-early service raises a fault.
// RULE21: Window time counts idle clocks and clears on every valid service.
`timescale 1ns/1ps
`default_nettype none

module wdm_top #(
  parameter int unsigned CM_TIMEOUT_CYCLES = wdm_pkg::CM_REJECT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_on_resetn,
  input wire logic [wdm_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [wdm_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic idle_clk_pin,
  input wire logic halt_mode,
  input wire logic idle_mode,
  input wire logic boot_entry,
  input wire logic boot_return,
  input wire logic watchdog_fault_out_in,
  output logic watchdog_fault_out_o,
  output logic watchdog_fault_out_oe
);
  import wdm_pkg::*;

  if (CM_TIMEOUT_CYCLES < 2)
  begin : g_bad_timeout
    $error("CM_TIMEOUT_CYCLES must be at least 2.");
  end

  function automatic logic addr_hit(logic [AXI_AW-1:0] a, logic [3:0] off);
    return (a[AXI_AW-1:4] == '0) && (a[3:2] == off[3:2]);
  endfunction : addr_hit

  function automatic logic addr_mapped(logic [AXI_AW-1:0] a);
    return a[AXI_AW-1:4] == '0;
  endfunction : addr_mapped

  function automatic logic [WIN_W-1:0] upper_limit(logic [1:0] win);
    return UPPER_BASE << win;
  endfunction : upper_limit

  // True on the tick that makes the selected idle-counter bit toggle.
  function automatic logic tap_hit(logic [IDLE_W-1:0] c, logic [2:0] sel);
    logic [IDLE_W-1:0] mask;
    mask = ~({IDLE_W{1'b1}} << (TAP_BASE + sel));
    return (c & mask) == mask;
  endfunction : tap_hit

  // Bus slave state.
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] bresp_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic aw_have_q;
  logic w_have_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic rd_svc_q;
  logic [31:0] rd_word;
  logic wr_go;
  logic svc_go;
  logic stat_wr;
  logic ctrl_wr;

  // Watchdog, monitor and timer state.
  wdm_state_t state_q;
  logic [WIN_W-1:0] win_cnt_q;
  logic [4:0] hold_cnt_q;
  logic first_done_q;
  logic lower_en_q;
  logic [1:0] win_q;
  logic cm_en_q;
  logic susp_q;
  logic [31:0] cm_cnt_q;
  logic [4:0] cm_rec_q;
  logic cm_fault_q;
  logic [IDLE_W-1:0] idle_cnt_q;
  logic [2:0] tap_sel_q;
  logic pending_q;
  logic idle_lvl;
  logic idle_lvl_q;
  logic pin_lvl;
  logic oe_q;
  logic out_q;
  logic tick;
  logic wake;
  logic suspended;
  logic svc_open;
  logic key_ok;
  logic svc_first_ok;
  logic svc_later_ok;
  logic svc_valid;
  logic svc_bad;
  logic expire;
  logic restart;
  logic cm_timeout;
  wdm_svc_t svc_wr;

  assign wr_go = aw_have_q & w_have_q & ~bvalid_q;
  assign svc_go = wr_go & addr_hit(awaddr_q, OFF_SERVICE) & wstrb_q[0];
  assign stat_wr = wr_go & addr_hit(awaddr_q, OFF_STATUS) & wstrb_q[0];
  assign ctrl_wr = wr_go & addr_hit(awaddr_q, OFF_IDLE_CTRL) & wstrb_q[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (awvalid && awready_q)
    begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      awaddr_q <= awaddr;
    end
    else if (wr_go)
      aw_have_q <= 1'b0;
    else if (!aw_have_q && !bvalid_q)
      awready_q <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_q <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (wvalid && wready_q)
    begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
    else if (wr_go)
      w_have_q <= 1'b0;
    else if (!w_have_q && !bvalid_q)
      wready_q <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  always_comb
  begin
    rd_word = '0;
    if (addr_hit(araddr, OFF_SERVICE))
      rd_word = 32'({win_q, SVC_KEY_READ, cm_en_q}); // see RULE6
    else if (addr_hit(araddr, OFF_STATUS))
    begin
      rd_word[STAT_FIRST_DONE] = first_done_q;
      rd_word[STAT_WD_FAULT] = state_q != WD_RUN;
      rd_word[STAT_CM_FAULT] = cm_fault_q;
      rd_word[STAT_PIN_LEVEL] = pin_lvl;
      rd_word[STAT_PENDING] = pending_q;
    end
    else if (addr_hit(araddr, OFF_IDLE_CTRL))
      rd_word = 32'(tap_sel_q);
    else if (addr_hit(araddr, OFF_IDLE_COUNT))
      rd_word = 32'(idle_cnt_q);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      rd_svc_q <= 1'b0;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rd_svc_q <= addr_hit(araddr, OFF_SERVICE);
    end
    else if (rvalid_q && rready)
      rvalid_q <= 1'b0;
    else if (!rvalid_q)
      arready_q <= 1'b1;
  end

  // Idle-timer clock and fault pin both arrive from outside this clock.
  wdm_sync3 #(.RESET_VAL(1'b0)) u_idle_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(idle_clk_pin),
    .dout(idle_lvl)
  );

  wdm_sync3 #(.RESET_VAL(1'b1)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(watchdog_fault_out_in),
    .dout(pin_lvl)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      idle_lvl_q <= 1'b0;
    else
      idle_lvl_q <= idle_lvl;
  end

  assign tick = idle_lvl & ~idle_lvl_q;

  // Only power-on clears the count, so the timer phase survives a reset.
  always_ff @(posedge aclk)
  begin
    if (!power_on_resetn)
      idle_cnt_q <= '0;
    else if (tick)
      idle_cnt_q <= IDLE_W'(idle_cnt_q + 1'b1); // see RULE11
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tap_sel_q <= TAP_SEL_RESET;
    else if (ctrl_wr)
      tap_sel_q <= (wdata_q[2:0] > TAP_SEL_MAX) ? TAP_SEL_MAX : wdata_q[2:0];
  end

  // A new toggle in the clearing cycle wins so no period is lost.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pending_q <= 1'b0;
    else if (tick && tap_hit(idle_cnt_q, tap_sel_q))
      pending_q <= 1'b1; // see RULE12
    else if (stat_wr && wdata_q[STAT_PENDING])
      pending_q <= 1'b0;
  end

  assign suspended = halt_mode | idle_mode;
  assign wake = susp_q & ~suspended;
  assign svc_wr = wdata_q[7:0]; // see RULE17
  assign svc_open = (state_q == WD_RUN) & ~cm_fault_q; // see RULE19
  assign key_ok = svc_wr.key == SVC_KEY;
  assign svc_first_ok = ~first_done_q & key_ok; // see RULE4, RULE14
  assign svc_later_ok = first_done_q & (svc_wr == {win_q, SVC_KEY, cm_en_q})
      & (~lower_en_q | (win_cnt_q >= LOWER_LIMIT)); // see RULE5, RULE20
  assign svc_valid = svc_go & svc_open & (svc_first_ok | svc_later_ok);
  assign svc_bad = svc_go & svc_open & ~(svc_first_ok | svc_later_ok);
  assign expire = (state_q == WD_RUN) & ~suspended
      & (win_cnt_q >= upper_limit(win_q)); // see RULE16, RULE20
  assign restart = svc_valid | wake | boot_entry | boot_return
      | ((state_q == WD_RELEASE) & pin_lvl); // see RULE10, RULE13, RULE18

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      susp_q <= 1'b0;
    else
      susp_q <= suspended;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      win_q <= WIN_MAX; // see RULE2
      cm_en_q <= CM_EN_RESET;
      first_done_q <= 1'b0;
    end
    else if (svc_valid && !first_done_q)
    begin
      win_q <= svc_wr.win; // see RULE3
      cm_en_q <= svc_wr.cm_en;
      first_done_q <= 1'b1;
    end
  end

  // Boot code services on its own schedule, so the early check is lifted.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lower_en_q <= 1'b0;
    else if (boot_entry)
      lower_en_q <= 1'b0;
    else if (boot_return || svc_valid)
      lower_en_q <= 1'b1; // see RULE15
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      win_cnt_q <= '0;
    else if (restart)
      win_cnt_q <= '0; // see RULE21
    else if (state_q == WD_RUN && !suspended && tick)
      win_cnt_q <= WIN_W'(win_cnt_q + 1'b1); // see RULE7
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= WD_RUN; // see RULE1
      hold_cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        WD_RUN:
        begin
          hold_cnt_q <= '0;
          if (svc_bad || expire)
            state_q <= WD_DRIVE;
        end
        WD_DRIVE:
        begin
          if (hold_cnt_q == FAULT_HOLD_TICKS)
            state_q <= WD_RELEASE; // see RULE19
          else if (!pin_lvl && tick)
            hold_cnt_q <= 5'(hold_cnt_q + 1'b1);
        end
        WD_RELEASE:
        begin
          if (pin_lvl)
            state_q <= WD_RUN;
        end
      endcase
    end
  end

  // The monitor sees the idle clock ungated by halt or idle, so a clock stopped in halt still faults.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick)
      cm_cnt_q <= '0; // see RULE8
    else if (cm_cnt_q != CM_TIMEOUT_CYCLES)
      cm_cnt_q <= 32'(cm_cnt_q + 1'b1);
  end

  assign cm_timeout = cm_cnt_q == CM_TIMEOUT_CYCLES;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !cm_fault_q || cm_timeout)
      cm_rec_q <= '0;
    else if (tick && cm_rec_q != CM_RECOVER_TICKS)
      cm_rec_q <= 5'(cm_rec_q + 1'b1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !cm_en_q)
      cm_fault_q <= 1'b0;
    else if (cm_timeout)
      cm_fault_q <= 1'b1;
    else if (cm_rec_q == CM_RECOVER_TICKS)
      cm_fault_q <= 1'b0;
  end

  // Open-drain pin: only ever pulled low, the pull-up makes the high level.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      oe_q <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      oe_q <= (state_q == WD_DRIVE) | cm_fault_q; // see RULE9
      out_q <= 1'b0;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign watchdog_fault_out_o = out_q;
  assign watchdog_fault_out_oe = oe_q;

  AST_RESET_QUIET: assert property (@(posedge aclk) // see RULE1
    !aresetn |=> !watchdog_fault_out_oe)
    else $error("Fault pin driven after a reset cycle.");

  AST_RESET_DEFAULTS: assert property (@(posedge aclk) // see RULE2
    $rose(aresetn) |-> win_q == WIN_MAX && cm_en_q && !first_done_q)
    else $error("Window or monitor not at defaults after reset.");

  AST_CONFIG_FROZEN: assert property (@(posedge aclk) // see RULE3
    disable iff (!aresetn) first_done_q |=> $stable(win_q) && $stable(cm_en_q))
    else $error("Configuration changed after first service.");

  AST_BAD_FIRST_KEY: assert property (@(posedge aclk) // see RULE4
    disable iff (!aresetn)
    svc_go && svc_open && !first_done_q && !key_ok |=> state_q == WD_DRIVE
      ##1 watchdog_fault_out_oe)
    else $error("Wrong first key did not drive the fault pin.");

  AST_LATER_MISMATCH: assert property (@(posedge aclk) // see RULE5
    disable iff (!aresetn)
    svc_go && svc_open && first_done_q && svc_wr != {win_q, SVC_KEY, cm_en_q}
      |=> state_q == WD_DRIVE)
    else $error("Mismatching service did not fault.");

  AST_KEY_READS_ZERO: assert property (@(posedge aclk) // see RULE6
    disable iff (!aresetn) rvalid_q && rd_svc_q |-> rdata_q[5:1] == '0)
    else $error("Service read exposed the key.");

  AST_SUSPEND_FREEZE: assert property (@(posedge aclk) // see RULE7
    disable iff (!aresetn)
    suspended && susp_q && !restart |=> $stable(win_cnt_q) && state_q != WD_DRIVE)
    else $error("Window ran while halted or idle.");

  AST_CM_PIN: assert property (@(posedge aclk) // see RULE9
    disable iff (!aresetn) cm_fault_q |=> watchdog_fault_out_oe)
    else $error("Clock fault did not pull the fault pin.");

  AST_FIRST_EARLY_OK: assert property (@(posedge aclk) // see RULE14
    disable iff (!aresetn)
    svc_go && svc_open && !first_done_q && key_ok |=> state_q == WD_RUN
      && first_done_q && win_cnt_q == '0)
    else $error("Early first service was refused.");

endmodule : wdm_top

`default_nettype wire

// >>> wdm_reset_model.sv
// Model of the system reset circuit and pull-up on the fault pin.
`timescale 1ns/1ps
`default_nettype none

module wdm_reset_model #(
  parameter int RISE_CYCLES = 3
) (
  input wire logic aclk,
  input wire logic drive_o,
  input wire logic drive_oe,
  output logic pin,
  output logic [7:0] falls
);
  int rise_q = RISE_CYCLES;

  initial falls = 8'h00;

  // The pull-up is weak, so a released pin reads high only a few cycles
  // later; a design that restarts its window too early would be caught.
  always @(posedge aclk)
  begin
    if (drive_oe && !drive_o)
      rise_q <= 0;
    else if (rise_q < RISE_CYCLES)
      rise_q <= rise_q + 1;
  end

  // Pulled up when nobody sinks it, low at once when the pin is driven.
  assign pin = (rise_q >= RISE_CYCLES) && !(drive_oe && !drive_o);

  // Each fault that pulls a high pin low counts as one reset request.
  always @(posedge aclk)
  begin
    if (rise_q >= RISE_CYCLES && drive_oe && !drive_o)
      falls <= falls + 8'h01;
  end

endmodule : wdm_reset_model
`default_nettype wire

// >>> wdm_top_bench.sv
// Self-checking bench for the windowed watchdog and clock monitor.
`timescale 1ns/1ps
`default_nettype none

module wdm_top_bench;
  import wdm_pkg::*;

  localparam logic [5:0] A_SVC = {2'h0, OFF_SERVICE};
  localparam logic [5:0] A_STAT = {2'h0, OFF_STATUS};
  localparam logic [5:0] A_CTRL = {2'h0, OFF_IDLE_CTRL};
  localparam logic [5:0] A_CNT = {2'h0, OFF_IDLE_COUNT};

  logic aclk = 1'b0, aresetn = 1'b0, power_on_resetn = 1'b0;
  logic [5:0] awaddr = 6'h0, araddr = 6'h0;
  logic [31:0] wdata = 32'h0, rdata, rd, c0;
  logic [3:0] wstrb = 4'hf, tick_q = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin, drv_o, drv_oe;
  logic [1:0] bresp, rresp, rsp;
  logic halt_mode = 1'b0, idle_mode = 1'b0, idle_run = 1'b1;
  logic boot_entry = 1'b0, boot_return = 1'b0, idle_clk_pin = 1'b0;
  logic [7:0] falls, f0;
  int fail_count = 0, comparisons = 0, cyc = 0, hold_cnt = 0, last_hold = 0;

  initial
  begin
    forever #2.5 aclk = ~aclk;
  end

  wdm_top #(.CM_TIMEOUT_CYCLES(200)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .power_on_resetn(power_on_resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .idle_clk_pin(idle_clk_pin), .halt_mode(halt_mode),
    .idle_mode(idle_mode), .boot_entry(boot_entry),
    .boot_return(boot_return), .watchdog_fault_out_in(pin),
    .watchdog_fault_out_o(drv_o), .watchdog_fault_out_oe(drv_oe));

  wdm_reset_model #(.RISE_CYCLES(3)) sys_rst_u (
    .aclk(aclk), .drive_o(drv_o), .drive_oe(drv_oe), .pin(pin),
    .falls(falls));

  // One idle tick every ten cycles; the clock stops low when halted.
  always @(posedge aclk)
  begin
    if (idle_run)
      tick_q <= (tick_q == 4'h9) ? 4'h0 : tick_q + 4'h1;
    idle_clk_pin <= idle_run && (tick_q < 4'h5);
  end

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    hold_cnt <= drv_oe ? hold_cnt + 1 : 0;
    if (!drv_oe && hold_cnt != 0)
      last_hold <= hold_cnt;
    if (cyc == 95000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      aw_done = aw_done || (awvalid && awready);
      w_done = w_done || (wvalid && wready);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    rsp = bresp;
  endtask : wr

  task automatic rd_reg(input logic [5:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
  endtask : rd_reg

  task automatic svc(input logic [1:0] w, input logic [4:0] k, input logic c);
    wr(A_SVC, {24'h0, w, k, c});
  endtask : svc

  task automatic quiet();
    repeat (60) @(posedge aclk);
    check({24'h0, falls}, {24'h0, f0});
  endtask : quiet

  // Waits for the pin to be pulled, checks the cause, lets it recover.
  task automatic expect_fault(input int unsigned st_bit);
    int n;
    n = 0;
    while (!drv_oe && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    check({31'h0, drv_oe}, 32'h1);
    check({31'h0, drv_o}, 32'h0);
    rd_reg(A_STAT);
    check(rd & (32'h1 << st_bit), 32'h1 << st_bit);
    idle_run <= 1'b1;
    halt_mode <= 1'b0;
    while (drv_oe) @(posedge aclk);
    repeat (20) @(posedge aclk);
    if (st_bit == STAT_WD_FAULT)
      check({31'h0, last_hold >= 155 && last_hold <= 200}, 32'h1);
  endtask : expect_fault

  initial
  begin
    repeat (10) @(posedge aclk);
    check({31'h0, drv_oe}, 32'h0);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    power_on_resetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd_reg(A_SVC);
    check(rd, {24'h0, WIN_MAX, SVC_KEY_READ, CM_EN_RESET});
    rd_reg(6'h10);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    f0 = falls;
    svc(2'h0, SVC_KEY, 1'b0);
    quiet();
    rd_reg(A_SVC);
    check(rd, {24'h0, 2'h0, SVC_KEY_READ, 1'b0});
    @(posedge aclk);
    boot_entry <= 1'b1;
    @(posedge aclk);
    boot_entry <= 1'b0;
    // The lower check is off here, so only the wrong window can fault.
    svc(2'h1, SVC_KEY, 1'b0);
    expect_fault(STAT_WD_FAULT);
    f0 = falls;
    svc(2'h0, SVC_KEY, 1'b0);
    quiet();
    @(posedge aclk);
    boot_return <= 1'b1;
    @(posedge aclk);
    boot_return <= 1'b0;
    svc(2'h0, SVC_KEY, 1'b0);
    expect_fault(STAT_WD_FAULT);
    // Past the lower limit, so only the idle-exit service makes this early.
    repeat (21000) @(posedge aclk);
    idle_mode <= 1'b1;
    repeat (20) @(posedge aclk);
    idle_mode <= 1'b0;
    svc(2'h0, SVC_KEY, 1'b0);
    expect_fault(STAT_WD_FAULT);
    // Just past the 2048-tick lower limit, well inside the 8k window.
    repeat (21000) @(posedge aclk);
    f0 = falls;
    svc(2'h0, SVC_KEY, 1'b0);
    quiet();
    rd_reg(A_CNT);
    c0 = rd;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // The idle clock needs a full period plus the synchroniser to tick again.
    repeat (24) @(posedge aclk);
    rd_reg(A_CNT);
    check({31'h0, rd > c0}, 32'h1);
    @(posedge aclk);
    halt_mode <= 1'b1;
    idle_run <= 1'b0;
    expect_fault(STAT_CM_FAULT);
    rd_reg(A_STAT);
    check(rd & (32'h1 << STAT_CM_FAULT), 32'h0);
    svc(WIN_MAX, 5'h0d, 1'b1);
    expect_fault(STAT_WD_FAULT);
    wr(A_CTRL, 32'h7);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd_reg(A_CTRL);
    check(rd, {29'h0, TAP_SEL_MAX});
    wr(A_CTRL, {29'h0, TAP_SEL_RESET});
    wr(A_STAT, 32'h1 << STAT_PENDING);
    rd_reg(A_STAT);
    check(rd & (32'h1 << STAT_PENDING), 32'h0);
    do rd_reg(A_STAT); while (!rd[STAT_PENDING]);
    rd_reg(A_CNT);
    check({31'h0, rd[TAP_BASE-1:0] < 64}, 32'h1);
    report_and_stop();
  end

endmodule : wdm_top_bench
`default_nettype wire
